// File: hw/irqf_pkg.sv
// constants of the interrupt request flag bank
// assumes one word-aligned AHB-Lite slot per register
package irqf_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int unsigned DATA_W = 16;
    localparam int unsigned EVT_W  = 4;
    localparam int unsigned NREG   = 4;
    // ----------------------------------------
    // byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_FLAGS_0    = 8'h00;
    localparam logic [7:0] OFS_FLAGS_1    = 8'h04;
    localparam logic [7:0] OFS_FLAGS_2    = 8'h08;
    localparam logic [7:0] OFS_FLAGS_3    = 8'h0c;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK   = 8'h14;
    // ----------------------------------------
    // implemented bits and reset values
    // ----------------------------------------
    localparam logic [15:0] IMPL_0    = 16'h0006;
    localparam logic [15:0] IMPL_1    = 16'hfffb;
    localparam logic [15:0] IMPL_2    = 16'hdfff;
    localparam logic [15:0] IMPL_3    = 16'h39ff;
    localparam logic [NREG-1:0][15:0] IMPL_ALL = {IMPL_3, IMPL_2, IMPL_1, IMPL_0};
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [3:0]  RST_EVT   = 4'h0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int OUT_COMPARE_1_FLAG     = 2;
    localparam int IN_CAPTURE_1_FLAG      = 1;
    localparam int SERIAL2_TX_FLAG        = 15;
    localparam int SERIAL2_RX_FLAG        = 14;
    localparam int EXT_IRQ_2_FLAG         = 13;
    localparam int TIMER_5_FLAG           = 12;
    localparam int TIMER_4_FLAG           = 11;
    localparam int OUT_COMPARE_4_FLAG     = 10;
    localparam int OUT_COMPARE_3_FLAG     = 9;
    localparam int DMA_CH2_DONE_FLAG      = 8;
    localparam int IN_CAPTURE_8_FLAG      = 7;
    localparam int IN_CAPTURE_7_FLAG      = 6;
    localparam int ADC_2_DONE_FLAG        = 5;
    localparam int EXT_IRQ_1_FLAG         = 4;
    localparam int PIN_CHANGE_NOTICE_FLAG = 3;
    localparam int I2C_1_MASTER_FLAG      = 1;
    localparam int I2C_1_SLAVE_FLAG       = 0;
    localparam int TIMER_6_FLAG           = 15;
    localparam int DMA_CH4_DONE_FLAG      = 14;
    localparam int OUT_COMPARE_8_FLAG     = 12;
    localparam int OUT_COMPARE_7_FLAG     = 11;
    localparam int OUT_COMPARE_6_FLAG     = 10;
    localparam int OUT_COMPARE_5_FLAG     = 9;
    localparam int IN_CAPTURE_6_FLAG      = 8;
    localparam int IN_CAPTURE_5_FLAG      = 7;
    localparam int IN_CAPTURE_4_FLAG      = 6;
    localparam int IN_CAPTURE_3_FLAG      = 5;
    localparam int DMA_CH3_DONE_FLAG      = 4;
    localparam int CAN_1_EVENT_FLAG       = 3;
    localparam int CAN_1_RX_READY_FLAG    = 2;
    localparam int SPI_2_EVENT_FLAG       = 1;
    localparam int SPI_2_ERROR_FLAG       = 0;
    localparam int DMA_CH5_DONE_FLAG      = 13;
    localparam int CODEC_PORT_EVENT_FLAG  = 12;
    localparam int CODEC_PORT_ERROR_FLAG  = 11;
    localparam int CAN_2_EVENT_FLAG       = 8;
    localparam int CAN_2_RX_READY_FLAG    = 7;
    localparam int EXT_IRQ_4_FLAG         = 6;
    localparam int EXT_IRQ_3_FLAG         = 5;
    localparam int TIMER_9_FLAG           = 4;
    localparam int TIMER_8_FLAG           = 3;
    localparam int I2C_2_MASTER_FLAG      = 2;
    localparam int I2C_2_SLAVE_FLAG       = 1;
    localparam int TIMER_7_FLAG           = 0;
    // ----------------------------------------
    // bus slave states
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD_WAIT, ST_RD_DONE} irqf_bus_state_type;
endpackage

// File: hw/irqf_flag_reg.sv
// one 16-bit request flag register
// assumes requests and writes are on clk
`timescale 1ns/100ps
module irqf_flag_reg
    import irqf_pkg::*;
#(
    parameter logic [15:0] IMPL = 16'hffff // implemented bits
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,    // software write this cycle
    input  wire logic [15:0] wr_data,  // software write data
    input  wire logic [15:0] src_req,  // source requests
    output logic      [15:0] flags_ff, // stored flags
    output logic             src_hit   // some implemented source fired
);
    // ----------------------------------------
    // next value
    // ----------------------------------------
    logic [15:0] nxt_flags; // value after this edge

    // write replaces, then requests are or-ed on top so a set beats a clear
    assign nxt_flags = ((wr_en ? wr_data : flags_ff) | src_req) & IMPL;
    assign src_hit   = |(src_req & IMPL);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    // flags come up cleared
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_ff <= RST_FLAGS;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end
endmodule // irqf_flag_reg

// File: hw/irqf_bank.sv
// interrupt request flag bank with an AHB-Lite register slave
// assumes sources are logic on clk; hsel decodes the slot
`timescale 1ns/100ps
module irqf_bank
    import irqf_pkg::*;
#(
    parameter int unsigned ADDR_W = 32 // bus address width
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    output logic                   irq,
    // first register sources
    input  wire logic              out_compare_1_req,
    input  wire logic              in_capture_1_req,
    // second register sources
    input  wire logic              serial2_tx_req,
    input  wire logic              serial2_rx_req,
    input  wire logic              ext_irq_2_req,
    input  wire logic              timer_5_req,
    input  wire logic              timer_4_req,
    input  wire logic              out_compare_4_req,
    input  wire logic              out_compare_3_req,
    input  wire logic              dma_ch2_done_req,
    input  wire logic              in_capture_8_req,
    input  wire logic              in_capture_7_req,
    input  wire logic              adc_2_done_req,
    input  wire logic              ext_irq_1_req,
    input  wire logic              pin_change_notice_req,
    input  wire logic              i2c_1_master_req,
    input  wire logic              i2c_1_slave_req,
    // third register sources
    input  wire logic              timer_6_req,
    input  wire logic              dma_ch4_done_req,
    input  wire logic              out_compare_8_req,
    input  wire logic              out_compare_7_req,
    input  wire logic              out_compare_6_req,
    input  wire logic              out_compare_5_req,
    input  wire logic              in_capture_6_req,
    input  wire logic              in_capture_5_req,
    input  wire logic              in_capture_4_req,
    input  wire logic              in_capture_3_req,
    input  wire logic              dma_ch3_done_req,
    input  wire logic              can_1_event_req,
    input  wire logic              can_1_rx_ready_req,
    input  wire logic              spi_2_event_req,
    input  wire logic              spi_2_error_req,
    // fourth register sources
    input  wire logic              dma_ch5_done_req,
    input  wire logic              codec_port_event_req,
    input  wire logic              codec_port_error_req,
    input  wire logic              can_2_event_req,
    input  wire logic              can_2_rx_ready_req,
    input  wire logic              ext_irq_4_req,
    input  wire logic              ext_irq_3_req,
    input  wire logic              timer_9_req,
    input  wire logic              timer_8_req,
    input  wire logic              i2c_2_master_req,
    input  wire logic              i2c_2_slave_req,
    input  wire logic              timer_7_req
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    irqf_bus_state_type state_ff;       // bus slave state
    irqf_bus_state_type nxt_state;      // its next value
    logic [7:0]         addr_ff;        // latched offset
    logic [31:0]        hrdata_ff;      // read data register
    logic [EVT_W-1:0]   evt_status_ff;  // sticky per-register events
    logic [EVT_W-1:0]   nxt_evt_status; // its next value
    logic [EVT_W-1:0]   evt_mask_ff;    // interrupt mask
    logic [15:0]        req_v [NREG];   // packed requests
    logic [15:0]        flags_v [NREG]; // stored flags
    logic [NREG-1:0]    wr_en;          // flag write strobes
    logic [NREG-1:0]    hit;            // source fired per register
    logic               take;           // address phase accepted
    logic               wr_cyc;         // write data phase
    logic               rd_cap;         // read data captured now
    logic [15:0]        rd_word;        // read mux result

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // true when the offset selects flag register idx
    function automatic logic flag_sel(input logic [7:0] a, input logic [1:0] idx);
        flag_sel = (a[7:4] == 4'h0) && (a[3:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    // ----------------------------------------
    // source packing
    // ----------------------------------------
    // each request lands on its own flag position
    always_comb
    begin
        req_v[0] = RST_FLAGS;
        req_v[1] = RST_FLAGS;
        req_v[2] = RST_FLAGS;
        req_v[3] = RST_FLAGS;
        req_v[0][OUT_COMPARE_1_FLAG]     = out_compare_1_req;
        req_v[0][IN_CAPTURE_1_FLAG]      = in_capture_1_req;
        req_v[1][SERIAL2_TX_FLAG]        = serial2_tx_req;
        req_v[1][SERIAL2_RX_FLAG]        = serial2_rx_req;
        req_v[1][EXT_IRQ_2_FLAG]         = ext_irq_2_req;
        req_v[1][TIMER_5_FLAG]           = timer_5_req;
        req_v[1][TIMER_4_FLAG]           = timer_4_req;
        req_v[1][OUT_COMPARE_4_FLAG]     = out_compare_4_req;
        req_v[1][OUT_COMPARE_3_FLAG]     = out_compare_3_req;
        req_v[1][DMA_CH2_DONE_FLAG]      = dma_ch2_done_req;
        req_v[1][IN_CAPTURE_8_FLAG]      = in_capture_8_req;
        req_v[1][IN_CAPTURE_7_FLAG]      = in_capture_7_req;
        req_v[1][ADC_2_DONE_FLAG]        = adc_2_done_req;
        req_v[1][EXT_IRQ_1_FLAG]         = ext_irq_1_req;
        req_v[1][PIN_CHANGE_NOTICE_FLAG] = pin_change_notice_req;
        req_v[1][I2C_1_MASTER_FLAG]      = i2c_1_master_req;
        req_v[1][I2C_1_SLAVE_FLAG]       = i2c_1_slave_req;
        req_v[2][TIMER_6_FLAG]           = timer_6_req;
        req_v[2][DMA_CH4_DONE_FLAG]      = dma_ch4_done_req;
        req_v[2][OUT_COMPARE_8_FLAG]     = out_compare_8_req;
        req_v[2][OUT_COMPARE_7_FLAG]     = out_compare_7_req;
        req_v[2][OUT_COMPARE_6_FLAG]     = out_compare_6_req;
        req_v[2][OUT_COMPARE_5_FLAG]     = out_compare_5_req;
        req_v[2][IN_CAPTURE_6_FLAG]      = in_capture_6_req;
        req_v[2][IN_CAPTURE_5_FLAG]      = in_capture_5_req;
        req_v[2][IN_CAPTURE_4_FLAG]      = in_capture_4_req;
        req_v[2][IN_CAPTURE_3_FLAG]      = in_capture_3_req;
        req_v[2][DMA_CH3_DONE_FLAG]      = dma_ch3_done_req;
        req_v[2][CAN_1_EVENT_FLAG]       = can_1_event_req;
        req_v[2][CAN_1_RX_READY_FLAG]    = can_1_rx_ready_req;
        req_v[2][SPI_2_EVENT_FLAG]       = spi_2_event_req;
        req_v[2][SPI_2_ERROR_FLAG]       = spi_2_error_req;
        req_v[3][DMA_CH5_DONE_FLAG]      = dma_ch5_done_req;
        req_v[3][CODEC_PORT_EVENT_FLAG]  = codec_port_event_req;
        req_v[3][CODEC_PORT_ERROR_FLAG]  = codec_port_error_req;
        req_v[3][CAN_2_EVENT_FLAG]       = can_2_event_req;
        req_v[3][CAN_2_RX_READY_FLAG]    = can_2_rx_ready_req;
        req_v[3][EXT_IRQ_4_FLAG]         = ext_irq_4_req;
        req_v[3][EXT_IRQ_3_FLAG]         = ext_irq_3_req;
        req_v[3][TIMER_9_FLAG]           = timer_9_req;
        req_v[3][TIMER_8_FLAG]           = timer_8_req;
        req_v[3][I2C_2_MASTER_FLAG]      = i2c_2_master_req;
        req_v[3][I2C_2_SLAVE_FLAG]       = i2c_2_slave_req;
        req_v[3][TIMER_7_FLAG]           = timer_7_req;
    end

    // ----------------------------------------
    // flag registers
    // ----------------------------------------
    // one register per slot; masks drop unimplemented bits
    for (genvar g = 0; g < NREG; g++)
    begin : g_flag
        assign wr_en[g] = wr_cyc && flag_sel(addr_ff, 2'(g));
        irqf_flag_reg #(
            .IMPL     (IMPL_ALL[g])
        ) u_flag (
            .clk      (clk),
            .rst_n    (rst_n),
            .wr_en    (wr_en[g]),
            .wr_data  (hwdata[15:0]),
            .src_req  (req_v[g]),
            .flags_ff (flags_v[g]),
            .src_hit  (hit[g])
        );
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    assign take      = hsel && htrans[1] && hready;
    assign wr_cyc    = (state_ff == ST_WR);
    assign rd_cap    = (state_ff == ST_RD_WAIT);
    assign hreadyout = (state_ff != ST_RD_WAIT); // reads take one wait state
    assign hresp     = 1'b0;                     // always okay
    assign hrdata    = hrdata_ff;

    // next bus state
    always_comb
    begin
        nxt_state = ST_IDLE;
        case (state_ff)
            ST_RD_WAIT:
                nxt_state = ST_RD_DONE; // data now registered
            ST_IDLE, ST_WR, ST_RD_DONE:
            begin
                if (take)
                    nxt_state = hwrite ? ST_WR : ST_RD_WAIT;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // bus state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // offset latched in the address phase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            addr_ff <= 8'h00;
        else if (take)
            addr_ff <= haddr[7:0];
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rd_word = RST_FLAGS;
        if (addr_ff == OFS_EVT_STATUS)
        begin
            rd_word[EVT_W-1:0] = evt_status_ff;
        end
        else if (addr_ff == OFS_EVT_MASK)
        begin
            rd_word[EVT_W-1:0] = evt_mask_ff;
        end
        else
        begin
            for (int i = 0; i < NREG; i++)
            begin
                if (flag_sel(addr_ff, 2'(i)))
                begin
                    rd_word = flags_v[i];
                end
            end
        end
    end

    // read data register, upper half zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hrdata_ff <= RST_RDATA;
        else if (rd_cap)
            hrdata_ff <= {16'h0000, rd_word};
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    // read clears, new events win over the clear
    always_comb
    begin
        nxt_evt_status = evt_status_ff;
        if (rd_cap && (addr_ff == OFS_EVT_STATUS))
        begin
            nxt_evt_status = RST_EVT;
        end
        nxt_evt_status = nxt_evt_status | hit;
    end

    // sticky status register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            evt_status_ff <= RST_EVT;
        else
            evt_status_ff <= nxt_evt_status;
    end

    // mask register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            evt_mask_ff <= RST_EVT;
        else if (wr_cyc && (addr_ff == OFS_EVT_MASK))
            evt_mask_ff <= hwdata[EVT_W-1:0];
    end

    assign irq = |(evt_status_ff & evt_mask_ff);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_src_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (|(req_v[2] & IMPL_2)) |=> ((flags_v[2] & $past(req_v[2] & IMPL_2)) == $past(req_v[2] & IMPL_2)))
        else $error("source request did not set its flag");
    a_read_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_cap && addr_ff == OFS_FLAGS_1) |=> (hrdata[15:0] == $past(flags_v[1])) && hrdata[31:16] == 16'h0000)
        else $error("flag read returned wrong data");
    a_reset_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |-> (flags_v[0] == 16'h0000) && (flags_v[1] == 16'h0000)
                          && (flags_v[2] == 16'h0000) && (flags_v[3] == 16'h0000))
        else $error("flags not cleared after reset");
    a_unimpl_second: assert property (@(posedge clk) disable iff (!rst_n)
        flags_v[1][2] == 1'b0)
        else $error("unimplemented bit set in second register");
    a_unimpl_fourth: assert property (@(posedge clk) disable iff (!rst_n)
        (flags_v[3][15:14] == 2'b00) && (flags_v[3][10:9] == 2'b00))
        else $error("unimplemented bit set in fourth register");
    a_map_compare1: assert property (@(posedge clk) disable iff (!rst_n)
        out_compare_1_req && in_capture_1_req |=> flags_v[0][2:1] == 2'b11)
        else $error("first register low bits mismatch");
    a_map_serial2: assert property (@(posedge clk) disable iff (!rst_n)
        serial2_tx_req |=> flags_v[1][15])
        else $error("transmit request not at bit 15");
    a_map_i2c1: assert property (@(posedge clk) disable iff (!rst_n)
        i2c_1_slave_req |=> flags_v[1][0])
        else $error("slave request not at bit 0");
    a_map_timer6: assert property (@(posedge clk) disable iff (!rst_n)
        timer_6_req |=> flags_v[2][15])
        else $error("timer 6 request not at bit 15");
    a_map_spi2: assert property (@(posedge clk) disable iff (!rst_n)
        spi_2_error_req |=> flags_v[2][0])
        else $error("spi error request not at bit 0");
    a_map_can2: assert property (@(posedge clk) disable iff (!rst_n)
        can_2_event_req |=> flags_v[3][8])
        else $error("can 2 event not at bit 8");
    a_map_timer7: assert property (@(posedge clk) disable iff (!rst_n)
        timer_7_req |=> flags_v[3][0])
        else $error("timer 7 request not at bit 0");
    a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en == 4'h0)[*2] |=> ($past(flags_v[2]) & ~flags_v[2]) == 16'h0000)
        else $error("flag dropped without a write");
    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en[1] && hwdata[15:0] == 16'h0000 && serial2_rx_req) |=> flags_v[1][14])
        else $error("clear beat a coincident request");
    a_write_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en[3] && hwdata[15:0] == 16'h0000 && req_v[3] == 16'h0000) |=> flags_v[3] == 16'h0000)
        else $error("zero write did not clear flags");
    a_write_sets: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en[2] |=> (flags_v[2] == ($past(hwdata[15:0] | req_v[2]) & IMPL_2)))
        else $error("software write did not land");
    a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_cap && addr_ff == OFS_EVT_STATUS && hit == 4'h0) |=> evt_status_ff == 4'h0 ##1 hreadyout)
        else $error("status read did not clear");
endmodule // irqf_bank

// File: sim/irqf_src_model.sv
// peripheral request sources facing the flag bank
// assumes the bench picks the sources to raise on clk
`timescale 1ns/100ps
module irqf_src_model
(
    input  wire logic             clk,
    input  wire logic [3:0][15:0] fire, // sources the bench raises
    output logic      [3:0][15:0] req   // one-cycle requests to the bank
);
    // a request is high for exactly the cycle after it is chosen
    always_ff @(posedge clk) req <= fire;
endmodule // irqf_src_model

// File: sim/tb_irqf_bank.sv
// self-checking bench of the request flag bank
// assumes one AHB-Lite master, hready fed back from hreadyout
`timescale 1ns/100ps
module tb_irqf_bank import irqf_pkg::*;;
    logic             clk = 0, rst_n = 0, hwrite = 0;
    logic      [31:0] haddr = 0, hwdata = 0, rdat;
    logic      [1:0]  htrans = 0;
    logic [3:0][15:0] fire = '0;
    wire              hready, hresp, irq;
    wire       [31:0] hrdata;
    wire  [3:0][15:0] r;
    int               errors = 0, samples_checked = 0, cyc = 0;
    logic      [15:0] imp [4] = '{16'h0006, 16'hfffb, 16'hdfff, 16'h39ff}; // implemented bits
    logic      [39:0] rows [10] = '{{8'h00, 16'hffff, 16'h0006}, {8'h04, 16'hffff, 16'hfffb},
        {8'h08, 16'hffff, 16'hdfff}, {8'h0c, 16'hffff, 16'h39ff}, {8'h00, 16'h0, 16'h0},
        {8'h04, 16'h0, 16'h0}, {8'h08, 16'h0, 16'h0}, {8'h0c, 16'h0, 16'h0}, {8'h18, 16'hffff, 16'h0},
        {8'h14, 16'hffff, 16'h000f}};
    irqf_src_model i_src (.clk(clk), .fire(fire), .req(r));
    irqf_bank i_dut (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .irq(irq), .out_compare_1_req(r[0][2]), .in_capture_1_req(r[0][1]), .serial2_tx_req(r[1][15]),
        .serial2_rx_req(r[1][14]), .ext_irq_2_req(r[1][13]), .timer_5_req(r[1][12]), .timer_4_req(r[1][11]),
        .out_compare_4_req(r[1][10]), .out_compare_3_req(r[1][9]), .dma_ch2_done_req(r[1][8]),
        .in_capture_8_req(r[1][7]), .in_capture_7_req(r[1][6]), .adc_2_done_req(r[1][5]),
        .ext_irq_1_req(r[1][4]), .pin_change_notice_req(r[1][3]), .i2c_1_master_req(r[1][1]),
        .i2c_1_slave_req(r[1][0]), .timer_6_req(r[2][15]), .dma_ch4_done_req(r[2][14]),
        .out_compare_8_req(r[2][12]), .out_compare_7_req(r[2][11]), .out_compare_6_req(r[2][10]),
        .out_compare_5_req(r[2][9]), .in_capture_6_req(r[2][8]), .in_capture_5_req(r[2][7]),
        .in_capture_4_req(r[2][6]), .in_capture_3_req(r[2][5]), .dma_ch3_done_req(r[2][4]),
        .can_1_event_req(r[2][3]), .can_1_rx_ready_req(r[2][2]), .spi_2_event_req(r[2][1]),
        .spi_2_error_req(r[2][0]), .dma_ch5_done_req(r[3][13]), .codec_port_event_req(r[3][12]),
        .codec_port_error_req(r[3][11]), .can_2_event_req(r[3][8]), .can_2_rx_ready_req(r[3][7]),
        .ext_irq_4_req(r[3][6]), .ext_irq_3_req(r[3][5]), .timer_9_req(r[3][4]), .timer_8_req(r[3][3]),
        .i2c_2_master_req(r[3][2]), .i2c_2_slave_req(r[3][1]), .timer_7_req(r[3][0]));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // print counts and verdict, then stop
    task automatic end_sim;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            end_sim;
        end
    end
    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single transfer: address phase, then data phase; read data kept in rdat
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        {haddr, hwrite, htrans} <= {24'h0, a, w, 2'b10};
        do @(posedge clk); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'b00, d};
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    // raise the chosen sources of one register for one cycle
    task automatic pulse(input int n, input logic [15:0] m);
        fire[n] <= m;
        @(posedge clk);
        fire <= '0;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int n = 0; n < 4; n++)
        begin
            bus(8'(4 * n), 1'b0, 0);
            chk(rdat, 0); // all clear after reset
        end
        foreach (rows[i])
        begin
            bus(rows[i][39:32], 1'b1, {16'h0, rows[i][31:16]});
            bus(rows[i][39:32], 1'b0, 0);
            chk(rdat, {16'h0, rows[i][15:0]}); // written value reads back, implemented bits only
            chk(hresp, 0); // slave always answers okay
        end
        for (int n = 0; n < 4; n++)
            for (int b = 0; b < 16; b++)
            begin
                pulse(n, 16'h1 << b);
                @(posedge clk);
                bus(8'(4 * n), 1'b0, 0);
                chk(rdat, {16'h0, imp[n] & (16'h1 << b)}); // source bit
                bus(8'(4 * n), 1'b1, 0);
            end
        bus(OFS_EVT_STATUS, 1'b0, 0);
        bus(OFS_EVT_MASK, 1'b1, 32'h2);
        pulse(1, 16'h0008);
        repeat (2) @(posedge clk);
        chk(irq, 1); // unmasked event raises irq
        pulse(0, 16'h0006);
        repeat (2) @(posedge clk);
        fork
            bus(OFS_FLAGS_1, 1'b1, 0);
            pulse(1, 16'h4000);
        join
        bus(OFS_FLAGS_1, 1'b0, 0);
        chk(rdat, 32'h4000); // zero clears, coincident request wins
        bus(OFS_EVT_STATUS, 1'b0, 0);
        chk(rdat, 32'h3); // sticky status of both registers
        bus(OFS_EVT_STATUS, 1'b0, 0);
        chk(rdat, 0); // status cleared by read
        chk(irq, 0); // irq drops with status
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(OFS_FLAGS_0, 1'b0, 0);
        chk(rdat, 0); // set flag lost in mid-run reset
        end_sim;
    end
endmodule // tb_irqf_bank
